// *** inc/servo_mon_pkg.sv ***
// Purpose: shared constants for the monitor-select command link
// Assumes: one clock for both ends, cyclic frames issued by the host end
// Notes: field positions, codes and host register offsets live here
// What this block does
// - main word: selectors at 16,20,24; 28-31 zero
// - sub word: 8-11 reserved; selectors at 12,16,20
// - six monitor slots, three per word
// - codes 0-7 give the eight base quantities
// - code 8 gives alarm, alarm overrides warning
// - code 9 gives feedback plus deviation
// - codes C,D follow common params 89, 8A
// - codes E,F follow optional monitor params
// - monitor values refreshed every cycle
// - parameter read uses command 40 hex
// - parameter write uses command 41 hex
// - host issues parameter commands only servo off
// - param 89 values 0-5 choose target quantities
package servo_mon_pkg;
	localparam int SEL_ONE_LSB    = 16;
	localparam int SEL_TWO_LSB    = 20;
	localparam int SEL_THREE_LSB  = 24;
	localparam int MAIN_RSVD_LSB  = 28;
	localparam int SUB_RSVD_LSB   = 8;
	localparam int SEL_FOUR_LSB   = 12;
	localparam int SEL_FIVE_LSB   = 16;
	localparam int SEL_SIX_LSB    = 20;
	localparam int SEL_W          = 4;
	localparam int SLOTS          = 6;

	typedef enum logic [3:0] {
		MON_FEEDBACK_POS  = 4'h0,
		MON_COMMAND_POS   = 4'h1,
		MON_DEVIATION     = 4'h2,
		MON_LATCH_ONE     = 4'h3,
		MON_LATCH_TWO     = 4'h4,
		MON_FEEDBACK_SPD  = 4'h5,
		MON_REF_SPD       = 4'h6,
		MON_REF_TORQUE    = 4'h7,
		MON_ALARM         = 4'h8,
		MON_LOOP_INPUT    = 4'h9,
		MON_RSVD_A        = 4'ha,
		MON_RSVD_B        = 4'hb,
		MON_COMMON_ONE    = 4'hc,
		MON_COMMON_TWO    = 4'hd,
		MON_OPTIONAL_ONE  = 4'he,
		MON_OPTIONAL_TWO  = 4'hf
	} monitor_code_t;

	localparam logic [7:0]  CMD_NONE            = 8'h00;
	localparam logic [7:0]  CMD_PARAM_READ      = 8'h40;
	localparam logic [7:0]  CMD_PARAM_WRITE     = 8'h41;
	localparam logic [15:0] PARAM_COMMON_ONE    = 16'h0089;
	localparam logic [15:0] PARAM_COMMON_TWO    = 16'h008a;
	localparam logic [15:0] PARAM_OPTIONAL_ONE  = 16'h0824;
	localparam logic [15:0] PARAM_OPTIONAL_TWO  = 16'h0825;
	localparam logic [31:0] PARAM_RESET         = 32'h00000000;

	localparam logic [15:0] CMN_TARGET_POS      = 16'h0000;
	localparam logic [15:0] CMN_INTERP_POS      = 16'h0001;
	localparam logic [15:0] CMN_POS_OFFSET      = 16'h0002;
	localparam logic [15:0] CMN_TARGET_SPD      = 16'h0003;
	localparam logic [15:0] CMN_SPEED_LIMIT     = 16'h0004;
	localparam logic [15:0] CMN_TORQUE_LIMIT    = 16'h0005;

	localparam logic [7:0] REG_MAIN_SEL        = 8'h00;
	localparam logic [7:0] REG_SUB_SEL         = 8'h04;
	localparam logic [7:0] REG_PARAM_NUM       = 8'h08;
	localparam logic [7:0] REG_PARAM_WDATA     = 8'h0c;
	localparam logic [7:0] REG_PARAM_CMD       = 8'h10;
	localparam logic [7:0] REG_PARAM_RDATA     = 8'h14;
	localparam logic [7:0] REG_LINK_STATUS     = 8'h18;
	localparam logic [7:0] REG_MON_BASE        = 8'h20;
	localparam int         FRAME_CYCLES        = 16;
endpackage

// *** inc/servo_link_if.sv ***
// Purpose: carrier joining the host end and the drive end
// Assumes: both ends on one clock
// Notes: frame_valid is a one-cycle pulse per communication cycle
`timescale 1ns/10ps
`default_nettype none
interface servo_link_if;
	logic                                   frame_valid;
	logic [31:0]                            main_ctrl;
	logic [31:0]                            sub_ctrl;
	logic [7:0]                             cmd_code;
	logic [15:0]                            param_num;
	logic [31:0]                            param_data;
	logic                                   resp_valid;
	logic [servo_mon_pkg::SLOTS-1:0][31:0]  mon;
	logic [servo_mon_pkg::SLOTS-1:0]        slot_ok;
	logic                                   param_ack;
	logic [31:0]                            param_rdata;
	logic                                   servo_on;

	modport host_end (output frame_valid, main_ctrl, sub_ctrl, cmd_code, param_num, param_data,
		input resp_valid, mon, slot_ok, param_ack, param_rdata, servo_on);
	modport drive_end (input frame_valid, main_ctrl, sub_ctrl, cmd_code, param_num, param_data,
		output resp_valid, mon, slot_ok, param_ack, param_rdata, servo_on);
endinterface
`default_nettype wire

// *** verilog/servo_drive_end.sv ***
// Purpose: drive end; decodes six selectors and fills the monitor slots
// Assumes: host keeps reserved fields zero and parameter traffic servo-off
// Notes: slots refresh every clock, selectors latch on each frame
`timescale 1ns/10ps
`default_nettype none
module servo_drive_end
(
	input  wire logic         CORE_CLK,
	input  wire logic         RST,
	servo_link_if.drive_end   LINK,
	input  wire logic [31:0]  FEEDBACK_POSITION,
	input  wire logic [31:0]  COMMAND_POSITION,
	input  wire logic [31:0]  POSITION_DEVIATION,
	input  wire logic [31:0]  LATCH_POSITION_ONE,
	input  wire logic [31:0]  LATCH_POSITION_TWO,
	input  wire logic [31:0]  FEEDBACK_SPEED,
	input  wire logic [31:0]  REFERENCE_SPEED,
	input  wire logic [31:0]  REFERENCE_TORQUE,
	input  wire logic         ALARM_ACTIVE,
	input  wire logic [31:0]  ALARM_INFO,
	input  wire logic         WARNING_ACTIVE,
	input  wire logic [31:0]  WARNING_INFO,
	input  wire logic [31:0]  TARGET_POSITION,
	input  wire logic [31:0]  INTERPOLATED_REFERENCE_POSITION,
	input  wire logic [31:0]  POSITION_OFFSET,
	input  wire logic [31:0]  TARGET_SPEED,
	input  wire logic [31:0]  SPEED_LIMIT_VALUE,
	input  wire logic [31:0]  TORQUE_LIMIT_VALUE,
	input  wire logic         SERVO_ON
);
	localparam int N = servo_mon_pkg::SLOTS;

	typedef struct packed {
		logic [N-1:0][3:0]   sel;
		logic [N-1:0][31:0]  mon;
		logic [N-1:0]        slot_ok;
		logic [31:0]         common_one_param;
		logic [31:0]         common_two_param;
		logic [31:0]         optional_one_param;
		logic [31:0]         optional_two_param;
		logic [31:0]         rdata;
		logic                ack;
		logic                resp_valid;
		logic                servo_on;
	} drive_state_t;

	drive_state_t st;
	drive_state_t next_st;

	// base quantities, codes 0 to 9; anything else yields zero
	function automatic logic [31:0] base_value(input logic [3:0] code);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (code)
			servo_mon_pkg::MON_FEEDBACK_POS: v = FEEDBACK_POSITION;
			servo_mon_pkg::MON_COMMAND_POS:  v = COMMAND_POSITION;
			servo_mon_pkg::MON_DEVIATION:    v = POSITION_DEVIATION;
			servo_mon_pkg::MON_LATCH_ONE:    v = LATCH_POSITION_ONE;
			servo_mon_pkg::MON_LATCH_TWO:    v = LATCH_POSITION_TWO;
			servo_mon_pkg::MON_FEEDBACK_SPD: v = FEEDBACK_SPEED;
			servo_mon_pkg::MON_REF_SPD:      v = REFERENCE_SPEED;
			servo_mon_pkg::MON_REF_TORQUE:   v = REFERENCE_TORQUE;
			servo_mon_pkg::MON_ALARM:
			begin
				// a live alarm hides any earlier warning
				if (ALARM_ACTIVE)
					v = ALARM_INFO;
				else if (WARNING_ACTIVE)
					v = WARNING_INFO;
			end
			servo_mon_pkg::MON_LOOP_INPUT:   v = FEEDBACK_POSITION + POSITION_DEVIATION;
			default:                         v = 32'h00000000;
		endcase
		return v;
	endfunction

	// common monitor choices; unlisted settings read zero
	function automatic logic [31:0] common_value(input logic [31:0] setting);
		logic [31:0] v;
		v = 32'h00000000;
		if (setting[31:16] == 16'h0000)
		begin
			unique case (setting[15:0])
				servo_mon_pkg::CMN_TARGET_POS:   v = TARGET_POSITION;
				servo_mon_pkg::CMN_INTERP_POS:   v = INTERPOLATED_REFERENCE_POSITION;
				servo_mon_pkg::CMN_POS_OFFSET:   v = POSITION_OFFSET;
				servo_mon_pkg::CMN_TARGET_SPD:   v = TARGET_SPEED;
				servo_mon_pkg::CMN_SPEED_LIMIT:  v = SPEED_LIMIT_VALUE;
				servo_mon_pkg::CMN_TORQUE_LIMIT: v = TORQUE_LIMIT_VALUE;
				default:                         v = 32'h00000000;
			endcase
		end
		return v;
	endfunction

	// optional monitors reuse the base list; a setting above 9 is not valid
	function automatic logic optional_ok(input logic [31:0] setting);
		return setting <= 32'(servo_mon_pkg::MON_LOOP_INPUT);
	endfunction

	function automatic logic [31:0] slot_value(input logic [3:0] code, input drive_state_t s);
		logic [31:0] v;
		v = 32'h00000000;
		unique case (code)
			servo_mon_pkg::MON_COMMON_ONE:   v = common_value(s.common_one_param);
			servo_mon_pkg::MON_COMMON_TWO:   v = common_value(s.common_two_param);
			servo_mon_pkg::MON_OPTIONAL_ONE:
				v = optional_ok(s.optional_one_param) ? base_value(s.optional_one_param[3:0])
					: 32'h00000000;
			servo_mon_pkg::MON_OPTIONAL_TWO:
				v = optional_ok(s.optional_two_param) ? base_value(s.optional_two_param[3:0])
					: 32'h00000000;
			servo_mon_pkg::MON_RSVD_A,
			servo_mon_pkg::MON_RSVD_B:       v = 32'h00000000;
			default:                         v = base_value(code);
		endcase
		return v;
	endfunction

	function automatic logic slot_valid(input logic [3:0] code, input drive_state_t s);
		logic ok;
		ok = 1'b1;
		if (code == servo_mon_pkg::MON_RSVD_A || code == servo_mon_pkg::MON_RSVD_B)
			ok = 1'b0;
		else if (code == servo_mon_pkg::MON_OPTIONAL_ONE)
			ok = optional_ok(s.optional_one_param);
		else if (code == servo_mon_pkg::MON_OPTIONAL_TWO)
			ok = optional_ok(s.optional_two_param);
		return ok;
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.resp_valid = 1'b0;
		next_st.servo_on = SERVO_ON;
		if (LINK.frame_valid)
		begin
			// reserved fields are not decoded, so stray bits there do no harm
			next_st.sel[0] = LINK.main_ctrl[servo_mon_pkg::SEL_ONE_LSB +: servo_mon_pkg::SEL_W];
			next_st.sel[1] = LINK.main_ctrl[servo_mon_pkg::SEL_TWO_LSB +: servo_mon_pkg::SEL_W];
			next_st.sel[2] = LINK.main_ctrl[servo_mon_pkg::SEL_THREE_LSB +: servo_mon_pkg::SEL_W];
			next_st.sel[3] = LINK.sub_ctrl[servo_mon_pkg::SEL_FOUR_LSB +: servo_mon_pkg::SEL_W];
			next_st.sel[4] = LINK.sub_ctrl[servo_mon_pkg::SEL_FIVE_LSB +: servo_mon_pkg::SEL_W];
			next_st.sel[5] = LINK.sub_ctrl[servo_mon_pkg::SEL_SIX_LSB +: servo_mon_pkg::SEL_W];
			next_st.resp_valid = 1'b1;
			if (LINK.cmd_code == servo_mon_pkg::CMD_PARAM_READ)
			begin
				next_st.ack = 1'b1;
				unique case (LINK.param_num)
					servo_mon_pkg::PARAM_COMMON_ONE:   next_st.rdata = st.common_one_param;
					servo_mon_pkg::PARAM_COMMON_TWO:   next_st.rdata = st.common_two_param;
					servo_mon_pkg::PARAM_OPTIONAL_ONE: next_st.rdata = st.optional_one_param;
					servo_mon_pkg::PARAM_OPTIONAL_TWO: next_st.rdata = st.optional_two_param;
					default:                           next_st.rdata = 32'h00000000;
				endcase
			end
			else if (LINK.cmd_code == servo_mon_pkg::CMD_PARAM_WRITE)
			begin
				next_st.ack = 1'b1;
				next_st.rdata = LINK.param_data;
				unique case (LINK.param_num)
					servo_mon_pkg::PARAM_COMMON_ONE:   next_st.common_one_param = LINK.param_data;
					servo_mon_pkg::PARAM_COMMON_TWO:   next_st.common_two_param = LINK.param_data;
					servo_mon_pkg::PARAM_OPTIONAL_ONE: next_st.optional_one_param = LINK.param_data;
					servo_mon_pkg::PARAM_OPTIONAL_TWO: next_st.optional_two_param = LINK.param_data;
					default:                           next_st.rdata = 32'h00000000;
				endcase
			end
		end
		// every slot is rebuilt each clock from the selectors in force
		for (int i = 0; i < N; i++)
		begin
			next_st.mon[i] = slot_value(next_st.sel[i], next_st);
			next_st.slot_ok[i] = slot_valid(next_st.sel[i], next_st);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			st <= '0;
			st.common_one_param <= servo_mon_pkg::PARAM_RESET;
			st.common_two_param <= servo_mon_pkg::PARAM_RESET;
			st.optional_one_param <= servo_mon_pkg::PARAM_RESET;
			st.optional_two_param <= servo_mon_pkg::PARAM_RESET;
		end
		else
			st <= next_st;
	end

	assign LINK.mon = st.mon;
	assign LINK.slot_ok = st.slot_ok;
	assign LINK.resp_valid = st.resp_valid;
	assign LINK.param_ack = st.ack;
	assign LINK.param_rdata = st.rdata;
	assign LINK.servo_on = st.servo_on;
endmodule
`default_nettype wire

// *** verilog/servo_host_end.sv ***
// Purpose: host end; AHB-Lite register slave that issues cyclic frames
// Assumes: single word transfers only, one parameter command at a time
// Notes: reads take one wait state, writes none
`timescale 1ns/10ps
`default_nettype none
module servo_host_end
#(
	parameter int FRAME_CYCLES = servo_mon_pkg::FRAME_CYCLES
)
(
	input  wire logic         CORE_CLK,
	input  wire logic         RST,
	input  wire logic         HSEL,
	input  wire logic [31:0]  HADDR,
	input  wire logic [1:0]   HTRANS,
	input  wire logic         HWRITE,
	input  wire logic [2:0]   HSIZE,
	input  wire logic [31:0]  HWDATA,
	input  wire logic         HREADY,
	output logic      [31:0]  HRDATA,
	output logic              HREADYOUT,
	output logic              HRESP,
	servo_link_if.host_end    LINK
);
	localparam int N = servo_mon_pkg::SLOTS;

	typedef struct packed {
		logic                wr_pend;
		logic                rd_pend;
		logic [7:0]          addr;
		logic [31:0]         hrdata;
		logic                hreadyout;
		logic [11:0]         main_sel;
		logic [11:0]         sub_sel;
		logic [15:0]         param_num;
		logic [31:0]         param_wdata;
		logic [31:0]         param_rdata;
		logic [7:0]          pend_cmd;
		logic                busy;
		logic                sent;
		logic                done;
		logic                refused;
		logic [15:0]         cnt;
		logic [N-1:0][31:0]  mon;
		logic [N-1:0]        slot_ok;
		logic                frame_valid;
		logic [7:0]          cmd_code;
	} host_state_t;

	host_state_t st;
	host_state_t next_st;

	function automatic logic [31:0] read_reg(input logic [7:0] a, input host_state_t s);
		logic [31:0] v;
		v = 32'h00000000;
		if (a == servo_mon_pkg::REG_MAIN_SEL)
			v = {20'h00000, s.main_sel};
		else if (a == servo_mon_pkg::REG_SUB_SEL)
			v = {20'h00000, s.sub_sel};
		else if (a == servo_mon_pkg::REG_PARAM_NUM)
			v = {16'h0000, s.param_num};
		else if (a == servo_mon_pkg::REG_PARAM_WDATA)
			v = s.param_wdata;
		else if (a == servo_mon_pkg::REG_PARAM_CMD)
			v = {29'h00000000, s.refused, s.done, s.busy};
		else if (a == servo_mon_pkg::REG_PARAM_RDATA)
			v = s.param_rdata;
		else if (a == servo_mon_pkg::REG_LINK_STATUS)
			v = {25'h0000000, s.slot_ok, LINK.servo_on};
		else if (a >= servo_mon_pkg::REG_MON_BASE && a < servo_mon_pkg::REG_MON_BASE + 8'(4 * N)
			&& a[1:0] == 2'b00)
			v = s.mon[3'((a - servo_mon_pkg::REG_MON_BASE) >> 2)];
		return v;
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.frame_valid = 1'b0;
		next_st.wr_pend = 1'b0;
		next_st.rd_pend = 1'b0;
		next_st.hreadyout = 1'b1;
		if (st.rd_pend)
			next_st.hrdata = read_reg(st.addr, st);
		if (st.wr_pend)
		begin
			if (st.addr == servo_mon_pkg::REG_MAIN_SEL)
				next_st.main_sel = HWDATA[11:0];
			else if (st.addr == servo_mon_pkg::REG_SUB_SEL)
				next_st.sub_sel = HWDATA[11:0];
			else if (st.addr == servo_mon_pkg::REG_PARAM_NUM)
				next_st.param_num = HWDATA[15:0];
			else if (st.addr == servo_mon_pkg::REG_PARAM_WDATA)
				next_st.param_wdata = HWDATA;
			else if (st.addr == servo_mon_pkg::REG_PARAM_CMD && !st.busy && HWDATA[1:0] != 2'b00)
			begin
				next_st.done = 1'b0;
				next_st.refused = 1'b0;
				if (LINK.servo_on)
					next_st.refused = 1'b1;
				else
				begin
					next_st.busy = 1'b1;
					next_st.sent = 1'b0;
					next_st.pend_cmd = HWDATA[1] ? servo_mon_pkg::CMD_PARAM_WRITE
						: servo_mon_pkg::CMD_PARAM_READ;
				end
			end
		end
		if (HSEL && HTRANS[1] && HREADY)
		begin
			next_st.addr = HADDR[7:0];
			next_st.wr_pend = HWRITE;
			next_st.rd_pend = !HWRITE;
			next_st.hreadyout = HWRITE;
		end
		if (st.cnt == 16'(FRAME_CYCLES - 1))
		begin
			next_st.cnt = 16'h0000;
			next_st.frame_valid = 1'b1;
			next_st.cmd_code = servo_mon_pkg::CMD_NONE;
			if (st.busy && !st.sent)
			begin
				next_st.cmd_code = st.pend_cmd;
				next_st.sent = 1'b1;
			end
		end
		else
			next_st.cnt = st.cnt + 16'h0001;
		if (LINK.resp_valid)
		begin
			next_st.mon = LINK.mon;
			next_st.slot_ok = LINK.slot_ok;
		end
		// the answer sets done after any clear from a write above
		if (LINK.param_ack && st.busy)
		begin
			next_st.busy = 1'b0;
			next_st.done = 1'b1;
			next_st.param_rdata = LINK.param_rdata;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			st <= '0;
			st.hreadyout <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign HRDATA = st.hrdata;
	assign HREADYOUT = st.hreadyout;
	assign HRESP = 1'b0;
	assign LINK.frame_valid = st.frame_valid;
	assign LINK.main_ctrl = {4'h0, st.main_sel, 16'h0000};
	assign LINK.sub_ctrl = {8'h00, st.sub_sel, 4'h0, 8'h00};
	assign LINK.cmd_code = st.cmd_code;
	assign LINK.param_num = st.param_num;
	assign LINK.param_data = st.param_wdata;
endmodule
`default_nettype wire

// *** tb/servo_link_asserts.sv ***
// Purpose: timing and field checks on the host-drive link
// Assumes: both ends on CORE_CLK, RST asynchronous active high
// Notes: watches the interface signals only
`timescale 1ns/10ps
`default_nettype none
module servo_link_asserts
#(
	parameter int FRAME_CYCLES = servo_mon_pkg::FRAME_CYCLES
)
(
	input wire logic                                  CORE_CLK,
	input wire logic                                  RST,
	input wire logic                                  frame_valid,
	input wire logic [31:0]                           main_ctrl,
	input wire logic [31:0]                           sub_ctrl,
	input wire logic [7:0]                            cmd_code,
	input wire logic                                  resp_valid,
	input wire logic [servo_mon_pkg::SLOTS-1:0][31:0] mon,
	input wire logic [servo_mon_pkg::SLOTS-1:0]       slot_ok,
	input wire logic                                  param_ack,
	input wire logic                                  servo_on
);
	logic [7:0] gap;
	logic       seen;

	// gap counts edges since the last frame; seen skips the first one after reset
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			gap  <= 8'h00;
			seen <= 1'b0;
		end
		else if (frame_valid)
		begin
			gap  <= 8'h00;
			seen <= 1'b1;
		end
		else
			gap <= gap + 8'h01;
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence frame_s;
		frame_valid;
	endsequence
	sequence reply_s;
		resp_valid;
	endsequence

	frame_reply_a: assert property (frame_s |=> reply_s)
		else $error("no reply one cycle after a frame");
	reply_cause_a: assert property (reply_s |-> $past(frame_valid))
		else $error("reply without a frame");
	main_rsvd_a: assert property (frame_s |-> main_ctrl[31:28] == 4'h0)
		else $error("main word top nibble not zero");
	sub_rsvd_a: assert property (frame_s |-> sub_ctrl[11:8] == 4'h0)
		else $error("sub word reserved nibble not zero");
	read_ack_a: assert property (frame_valid && cmd_code == 8'h40 |=> param_ack and reply_s)
		else $error("parameter read not acknowledged");
	write_ack_a: assert property (frame_valid && cmd_code == 8'h41 |=> param_ack and reply_s)
		else $error("parameter write not acknowledged");
	idle_ack_a: assert property (frame_valid && cmd_code == 8'h00 |=> !param_ack)
		else $error("ack without a command");
	servo_off_a: assert property (frame_valid && cmd_code != 8'h00 |-> !servo_on)
		else $error("parameter command sent with servo on");
	rsvd_slot_a: assert property (frame_valid && main_ctrl[19:16] inside {4'ha, 4'hb}
		|=> !slot_ok[0] && mon[0] == 32'h0)
		else $error("reserved code gave a valid slot");
	slot_valid_a: assert property (frame_valid && sub_ctrl[15:12] < 4'ha |=> slot_ok[3])
		else $error("fourth slot not valid for a base code");
	frame_gap_a: assert property (seen |-> (frame_valid == (gap == FRAME_CYCLES - 1)))
		else $error("frame spacing wrong");
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for host end and drive end joined by the link
// Assumes: AHB-Lite single word transfers, one slave
// Notes: expected read data queued by the driver, compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int FC = 8;
	typedef struct { string nm; logic [31:0] v; logic [31:0] m; } note_t;
	logic clk, rst, hsel, hwrite, son, alm, wrn;
	logic pend = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, ainfo, winfo;
	logic [1:0] htrans;
	logic hreadyout, hresp;
	logic [31:0] base[8];
	logic [31:0] tgt[6];
	logic [31:0] pv[4];
	logic [3:0] sel[6];
	note_t q[$];
	int n_mismatch, comparisons, cyc;
	servo_link_if link_i();
	servo_host_end #(.FRAME_CYCLES(FC)) servo_host_end_i (.CORE_CLK(clk), .RST(rst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .LINK(link_i));
	servo_drive_end servo_drive_end_i (.CORE_CLK(clk), .RST(rst), .LINK(link_i),
		.FEEDBACK_POSITION(base[0]), .COMMAND_POSITION(base[1]), .POSITION_DEVIATION(base[2]),
		.LATCH_POSITION_ONE(base[3]), .LATCH_POSITION_TWO(base[4]), .FEEDBACK_SPEED(base[5]),
		.REFERENCE_SPEED(base[6]), .REFERENCE_TORQUE(base[7]), .ALARM_ACTIVE(alm),
		.ALARM_INFO(ainfo), .WARNING_ACTIVE(wrn), .WARNING_INFO(winfo),
		.TARGET_POSITION(tgt[0]), .INTERPOLATED_REFERENCE_POSITION(tgt[1]),
		.POSITION_OFFSET(tgt[2]), .TARGET_SPEED(tgt[3]), .SPEED_LIMIT_VALUE(tgt[4]),
		.TORQUE_LIMIT_VALUE(tgt[5]), .SERVO_ON(son));
	servo_link_asserts #(.FRAME_CYCLES(FC)) servo_link_asserts_i (.CORE_CLK(clk), .RST(rst),
		.frame_valid(link_i.frame_valid), .main_ctrl(link_i.main_ctrl),
		.sub_ctrl(link_i.sub_ctrl), .cmd_code(link_i.cmd_code), .resp_valid(link_i.resp_valid),
		.mon(link_i.mon), .slot_ok(link_i.slot_ok), .param_ack(link_i.param_ack),
		.servo_on(link_i.servo_on));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] bval(input logic [31:0] c);
		if (c < 8) return base[c[2:0]];
		if (c == 8) return alm ? ainfo : (wrn ? winfo : 32'h0);
		if (c == 9) return base[0] + base[2];
		return 32'h0;
	endfunction

	// bit 32 is slot validity, the rest the monitor value
	function automatic logic [32:0] mval(input logic [3:0] c);
		if (c inside {4'ha, 4'hb}) return 33'h0;
		if (c < 4'hc) return {1'b1, bval({28'h0, c})};
		if (c < 4'he) return {1'b1, (pv[c-12] < 6) ? tgt[pv[c-12]] : 32'h0};
		return {(pv[c-12] < 10), bval(pv[c-12])};
	endfunction

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
		q.push_back('{n, e, m});
		ahb(1'b0, a, 32'h0);
	endtask

	// result appears at the edge ending a read data phase
	always @(posedge clk)
	begin
		if (pend && hreadyout === 1'b1 && q.size() > 0)
		begin
			note_t t;
			t = q.pop_front();
			comparisons++;
			if ((hrdata & t.m) !== (t.v & t.m))
			begin
				n_mismatch++;
				$display("CHECK FAILED %s expected %h seen %h", t.nm, t.v & t.m, hrdata & t.m);
			end
			// the slave never signals an error, so every read data phase checked here must end OKAY
			comparisons++;
			if (hresp !== 1'b0)
			begin
				n_mismatch++;
				$display("CHECK FAILED hresp expected 0 seen %b", hresp);
			end
		end
		if (hsel && htrans[1] && hreadyout && !hwrite)
			pend = 1'b1;
		else if (hreadyout)
			pend = 1'b0;
	end

	task automatic prm(input int k, input logic [15:0] num, input logic [31:0] val);
		ahb(1'b1, servo_mon_pkg::REG_PARAM_NUM, {16'h0, num});
		ahb(1'b1, servo_mon_pkg::REG_PARAM_WDATA, val);
		ahb(1'b1, servo_mon_pkg::REG_PARAM_CMD, 32'h2);
		repeat (2 * FC + 4) @(posedge clk);
		pv[k] = val;
		rd(servo_mon_pkg::REG_PARAM_CMD, 32'h2, 32'h2, "write done");
		rd(servo_mon_pkg::REG_PARAM_RDATA, val, '1, "write echo");
		ahb(1'b1, servo_mon_pkg::REG_PARAM_CMD, 32'h1);
		repeat (2 * FC + 4) @(posedge clk);
		rd(servo_mon_pkg::REG_PARAM_RDATA, val, '1, "read back");
	endtask

	task automatic chk(input int it);
		logic [32:0] r;
		logic [5:0]  ok;
		@(posedge clk);
		foreach (base[i]) base[i] <= $urandom;
		foreach (tgt[i]) tgt[i] <= $urandom;
		ainfo <= $urandom;
		winfo <= $urandom;
		alm <= 1'($urandom);
		wrn <= 1'($urandom);
		foreach (sel[i]) sel[i] = 4'(it + i);
		ahb(1'b1, servo_mon_pkg::REG_MAIN_SEL, {20'h0, sel[2], sel[1], sel[0]});
		ahb(1'b1, servo_mon_pkg::REG_SUB_SEL, {20'h0, sel[5], sel[4], sel[3]});
		repeat (2 * FC + 2) @(posedge clk);
		for (int i = 0; i < 6; i++)
		begin
			r = mval(sel[i]);
			ok[i] = r[32];
			rd(8'(servo_mon_pkg::REG_MON_BASE + 4 * i), r[31:0], '1, "monitor slot");
		end
		rd(servo_mon_pkg::REG_LINK_STATUS, {25'h0, ok, 1'b0}, '1, "link status");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	end

	initial
	begin
		{hsel, hwrite, son, alm, wrn} = '0;
		{haddr, hwdata, ainfo, winfo} = '0;
		htrans = 2'b00;
		foreach (base[i]) base[i] = '0;
		foreach (tgt[i]) tgt[i] = '0;
		foreach (pv[i]) pv[i] = '0;
		rst = 1'b1;
		void'($urandom(8002));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(servo_mon_pkg::REG_LINK_STATUS, 32'h0, '1, "reset status");
		rd(servo_mon_pkg::REG_PARAM_CMD, 32'h0, '1, "reset command");
		ahb(1'b1, 8'hfc, 32'h5a5a5a5a);
		rd(8'hfc, 32'h0, '1, "unmapped");
		for (int it = 0; it < 16; it++) chk(it);
		for (int k = 0; k < 6; k++)
		begin
			prm(0, 16'h0089, k);
			prm(1, 16'h008a, 5 - k);
			chk(12);
		end
		prm(2, 16'h0824, 9);
		prm(3, 16'h0825, 12);
		chk(12);
		chk(14);
		son <= 1'b1;
		repeat (4) @(posedge clk);
		ahb(1'b1, servo_mon_pkg::REG_PARAM_CMD, 32'h2);
		repeat (2 * FC + 4) @(posedge clk);
		rd(servo_mon_pkg::REG_PARAM_CMD, 32'h4, 32'h4, "refused");
		rd(servo_mon_pkg::REG_LINK_STATUS, 32'h1, 32'h1, "servo on");
		repeat (4) @(posedge clk);
		tally_and_finish;
	end
endmodule
`default_nettype wire
